// [rtl/pimc_regs.sv]
`timescale 1ns/10ps
module pimc_regs
	import pimc_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [3:0] timer_match,
	input wire logic [15:0] event_timer_low,
	input wire logic [15:0] secondary_compare_two,
	input wire logic security_done,
	input wire logic buffer_error,
	input wire logic wake_event,
	input wire logic rx_len_strobe,
	input wire logic [6:0] rx_len_in,
	output logic irq_n,
	output logic timer_three_abort_en,
	output logic pan_coordinator_first,
	output logic [1:0] channel_assess_type,
	output logic promiscuous_en,
	output logic frame_length_ok,
	output logic event_timer_load
);
	pimc_state_t s_q;
	pimc_state_t s_d;
	logic [7:0] ev_set;
	logic [7:0] ev_clr;
	logic [7:0] eff_mask;
	logic [5:0] ar_idx;
	logic t2p_eq_now;
	logic do_write;

	function automatic logic [7:0] rd_mux(input logic [5:0] idx, input pimc_state_t s);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			PIMC_IDX_CTRL3: v = s.ctrl3;
			PIMC_IDX_RXLEN: v = {1'b0, s.rxlen};
			PIMC_IDX_CTRL4: v = s.ctrl4 & ~(8'h01 << PIMC_B_LOAD);
			PIMC_IDX_STAT: v = s.status;
			PIMC_IDX_XMASK: v = s.xmask;
			default: v = 8'h00;
		endcase
		return v;
	endfunction

	always_comb
	begin
		s_d = s_q;
		ev_set = 8'h00;
		ev_clr = 8'h00;
		ar_idx = s_axi_araddr[7:2];
		s_d.load_p = 1'b0;
		// equality is edge-detected so a held match does not refill a flag just read clear
		t2p_eq_now = (event_timer_low == secondary_compare_two);
		s_d.t2p_eq = t2p_eq_now;

		if (s_axi_awvalid && s_q.awready)
		begin
			s_d.aw_full = 1'b1;
			s_d.aw_idx = s_axi_awaddr[7:2];
		end
		if (s_axi_wvalid && s_q.wready)
		begin
			s_d.w_full = 1'b1;
			s_d.w_data = s_axi_wdata[7:0];
			s_d.w_lane0 = s_axi_wstrb[0];
		end
		do_write = s_q.aw_full && s_q.w_full && !s_q.bvalid;
		if (s_q.bvalid && s_axi_bready)
			s_d.bvalid = 1'b0;
		if (do_write)
		begin
			s_d.aw_full = 1'b0;
			s_d.w_full = 1'b0;
			s_d.bvalid = 1'b1;
			if (s_q.w_lane0)
			begin
				case (s_q.aw_idx)
					PIMC_IDX_CTRL3: s_d.ctrl3 = s_q.w_data & PIMC_CTRL3_WMASK;
					PIMC_IDX_CTRL4:
					begin
						s_d.ctrl4 = s_q.w_data & ~(8'h01 << PIMC_B_LOAD);
						// stored bit is always zero, so any one written is a rising edge
						s_d.load_p = s_q.w_data[PIMC_B_LOAD];
					end
					PIMC_IDX_XMASK: s_d.xmask = s_q.w_data & PIMC_CTRL3_WMASK;
					default: s_d.xmask = s_q.xmask;
				endcase
			end
		end

		if (s_q.rvalid && s_axi_rready)
			s_d.rvalid = 1'b0;
		if (s_axi_arvalid && s_q.arready)
		begin
			s_d.rvalid = 1'b1;
			s_d.rdata = rd_mux(ar_idx, s_q);
			if (ar_idx == PIMC_IDX_STAT)
				ev_clr = 8'hFF;
		end

		// flags set regardless of any mask; masks only act on the request line
		ev_set[7:4] = timer_match & s_q.ctrl3[7:4];
		ev_set[PIMC_B_TMR2] = ev_set[PIMC_B_TMR2]
			| (s_q.ctrl4[PIMC_B_T2P] && t2p_eq_now && !s_q.t2p_eq);
		ev_set[PIMC_B_SEC] = security_done;
		ev_set[PIMC_B_BUF] = buffer_error;
		ev_set[PIMC_B_WAKE] = wake_event;
		// set beats read-clear so an event in the read cycle survives
		s_d.status = (s_q.status & ~ev_clr) | ev_set;

		eff_mask = s_q.xmask | {4'h0, 1'b0, s_q.ctrl3[2:0]};
		s_d.irq_n = !((|(s_d.status & ~eff_mask)) && !s_q.ctrl4[PIMC_B_GMASK]);

		if (rx_len_strobe)
		begin
			s_d.rxlen = rx_len_in;
			s_d.len_ok = (rx_len_in >= PIMC_LEN_MIN) && (rx_len_in <= PIMC_LEN_MAX);
		end

		s_d.awready = !s_d.aw_full && !s_d.bvalid;
		s_d.wready = !s_d.w_full && !s_d.bvalid;
		s_d.arready = !s_d.rvalid;
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_q <= '0;
			s_q.ctrl3 <= PIMC_CTRL3_RST;
			s_q.ctrl4 <= PIMC_CTRL4_RST;
			s_q.xmask <= PIMC_XMASK_RST;
			s_q.irq_n <= 1'b1;
		end
		else
			s_q <= s_d;
	end

	assign s_axi_awready = s_q.awready;
	assign s_axi_wready = s_q.wready;
	assign s_axi_bvalid = s_q.bvalid;
	assign s_axi_bresp = PIMC_RESP_OKAY;
	assign s_axi_arready = s_q.arready;
	assign s_axi_rvalid = s_q.rvalid;
	assign s_axi_rdata = {24'h000000, s_q.rdata};
	assign s_axi_rresp = PIMC_RESP_OKAY;
	assign irq_n = s_q.irq_n;
	assign timer_three_abort_en = s_q.ctrl4[PIMC_B_T3ABT];
	assign pan_coordinator_first = s_q.ctrl4[PIMC_B_PANC];
	assign channel_assess_type = s_q.ctrl4[PIMC_B_CCA_LO +: 2];
	assign promiscuous_en = s_q.ctrl4[PIMC_B_PROM];
	assign frame_length_ok = s_q.len_ok;
	assign event_timer_load = s_q.load_p;

	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	cmp_gate_a: assert property (!s_q.ctrl3[7] && !s_q.status[7] |=> !s_q.status[7])
		else $error("timer four flag set while its enable is clear");
	cmp_pass_a: assert property (s_q.ctrl3[PIMC_B_CMP_LO] && timer_match[0]
		|=> s_q.status[PIMC_B_CMP_LO])
		else $error("enabled timer one match did not set its flag");
	sec_mask_a: assert property (s_q.ctrl3[PIMC_B_SEC] && s_d.status == 8'h04 |=> irq_n)
		else $error("masked security event drove the request line");
	sec_pass_a: assert property (!s_q.ctrl3[PIMC_B_SEC] && !s_q.xmask[PIMC_B_SEC]
		&& !s_q.ctrl4[PIMC_B_GMASK] && security_done |=> !irq_n)
		else $error("unmasked security event did not assert request");
	buf_block_a: assert property (s_q.ctrl3[PIMC_B_BUF] && s_d.status == 8'h02 |=> irq_n)
		else $error("masked buffer error drove the request line");
	wake_block_a: assert property (s_q.ctrl3[PIMC_B_WAKE] && s_d.status == 8'h01 |=> irq_n)
		else $error("masked wake drove the request line");
	buf_mask_a: assert property (!s_q.ctrl3[PIMC_B_BUF] && !s_q.ctrl4[PIMC_B_GMASK]
		&& !s_q.xmask[PIMC_B_BUF] && buffer_error |=> !irq_n)
		else $error("unmasked buffer error did not assert request");
	wake_irq_a: assert property (!s_q.ctrl3[PIMC_B_WAKE] && !s_q.ctrl4[PIMC_B_GMASK]
		&& !s_q.xmask[PIMC_B_WAKE] && wake_event |=> !irq_n)
		else $error("unmasked wake did not assert request");
	global_mask_a: assert property (s_q.ctrl4[PIMC_B_GMASK] |=> irq_n)
		else $error("request asserted under global mask");

	// mode outputs must follow a committed lane-0 write to the mode register
	t3_abort_a: assert property (do_write && s_q.w_lane0 && s_q.aw_idx == PIMC_IDX_CTRL4
		|=> timer_three_abort_en == $past(s_q.w_data[PIMC_B_T3ABT]))
		else $error("timer three abort enable not updated");
	pan_first_a: assert property (do_write && s_q.w_lane0 && s_q.aw_idx == PIMC_IDX_CTRL4
		|=> pan_coordinator_first == $past(s_q.w_data[PIMC_B_PANC]))
		else $error("coordinator option not updated");
	cca_type_a: assert property (do_write && s_q.w_lane0 && s_q.aw_idx == PIMC_IDX_CTRL4
		|=> channel_assess_type == $past(s_q.w_data[PIMC_B_CCA_LO +: 2]))
		else $error("assessment type not updated");
	prom_mode_a: assert property (do_write && s_q.w_lane0 && s_q.aw_idx == PIMC_IDX_CTRL4
		|=> promiscuous_en == $past(s_q.w_data[PIMC_B_PROM]))
		else $error("promiscuous option not updated");
	load_zero_a: assert property (!s_q.ctrl4[PIMC_B_LOAD])
		else $error("stored load bit not zero");
	load_pulse_a: assert property (event_timer_load |=> !event_timer_load)
		else $error("timer load held longer than one cycle");
	load_cause_a: assert property (event_timer_load |-> $past(do_write)
		&& $past(s_q.aw_idx) == PIMC_IDX_CTRL4 && $past(s_q.w_data[PIMC_B_LOAD]))
		else $error("timer load without a write of one");
	len_check_a: assert property (rx_len_strobe |=> frame_length_ok
		== ($past(rx_len_in) >= PIMC_LEN_MIN))
		else $error("frame length check wrong");
	t2p_set_a: assert property (s_q.ctrl4[PIMC_B_T2P] && t2p_eq_now && !s_q.t2p_eq
		|=> s_q.status[PIMC_B_TMR2])
		else $error("secondary match did not set timer two flag");
	rxlen_show_a: assert property (rx_len_strobe |=> s_q.rxlen == $past(rx_len_in))
		else $error("frame length not captured");
	flag_sticky_a: assert property (wake_event |=> s_q.status[PIMC_B_WAKE])
		else $error("masked wake did not set its flag");
	irq_level_a: assert property (s_q.status == 8'h00 |-> irq_n)
		else $error("request asserted with no flag set");
	irq_unmask_a: assert property ((|(s_d.status & ~eff_mask)) && !s_q.ctrl4[PIMC_B_GMASK]
		|=> !irq_n)
		else $error("unmasked flag did not assert request");
	// read-clear must not lose an event but must drop a flag with no new event
	stat_clear_a: assert property (s_axi_arvalid && s_axi_arready && ar_idx == PIMC_IDX_STAT
		&& !wake_event |=> !s_q.status[PIMC_B_WAKE])
		else $error("status read did not clear wake flag");

	// responses must stand until the host takes them
	bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("write response dropped before handshake");
	rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready
		|=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read response changed before handshake");

	wr_ctrl4_c: cover property (do_write && s_q.aw_idx == PIMC_IDX_CTRL4);
	rd_stat_c: cover property (s_axi_arvalid && s_axi_arready && ar_idx == PIMC_IDX_STAT);
	irq_on_c: cover property (irq_n ##1 !irq_n);
	load_c: cover property (event_timer_load);
	mask_hold_c: cover property (wake_event && s_q.ctrl3[PIMC_B_WAKE]);
endmodule

// [shared/pimc_pkg.sv]
package pimc_pkg;
	localparam logic [5:0] PIMC_IDX_CTRL3 = 6'h05;
	localparam logic [5:0] PIMC_IDX_RXLEN = 6'h06;
	localparam logic [5:0] PIMC_IDX_CTRL4 = 6'h07;
	localparam logic [5:0] PIMC_IDX_STAT = 6'h10;
	localparam logic [5:0] PIMC_IDX_XMASK = 6'h11;
	localparam logic [7:0] PIMC_CTRL3_RST = 8'h06;
	localparam logic [7:0] PIMC_CTRL4_RST = 8'h08;
	localparam logic [7:0] PIMC_XMASK_RST = 8'h00;
	localparam logic [7:0] PIMC_CTRL3_WMASK = 8'hF7;
	localparam int PIMC_B_CMP_LO = 4;
	localparam int PIMC_B_SEC = 2;
	localparam int PIMC_B_BUF = 1;
	localparam int PIMC_B_WAKE = 0;
	localparam int PIMC_B_TMR2 = 5;
	localparam int PIMC_B_GMASK = 7;
	localparam int PIMC_B_T3ABT = 6;
	localparam int PIMC_B_PANC = 5;
	localparam int PIMC_B_CCA_LO = 3;
	localparam int PIMC_B_LOAD = 2;
	localparam int PIMC_B_PROM = 1;
	localparam int PIMC_B_T2P = 0;
	localparam logic [6:0] PIMC_LEN_MIN = 7'h05;
	localparam logic [6:0] PIMC_LEN_MAX = 7'h7F;
	localparam logic [1:0] PIMC_RESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		PIMC_CCA_ED = 2'b00,
		PIMC_CCA_M1 = 2'b01,
		PIMC_CCA_M2 = 2'b10,
		PIMC_CCA_M3 = 2'b11
	} pimc_cca_t;

	typedef struct packed {
		logic aw_full;
		logic [5:0] aw_idx;
		logic w_full;
		logic [7:0] w_data;
		logic w_lane0;
		logic awready;
		logic wready;
		logic bvalid;
		logic arready;
		logic rvalid;
		logic [7:0] rdata;
		logic [7:0] ctrl3;
		logic [7:0] ctrl4;
		logic [7:0] xmask;
		logic [7:0] status;
		logic [6:0] rxlen;
		logic len_ok;
		logic load_p;
		logic t2p_eq;
		logic irq_n;
	} pimc_state_t;
endpackage

// [dv/pimc_host_model.sv]
`timescale 1ns/10ps
module pimc_host_model (
	input wire logic aclk,
	input wire logic irq_n,
	output int n_req
);
	logic irq_n_q;
	// a held request counts once; the model only counts falling edges of irq_n and never reads status
	always @(posedge aclk)
	begin
		irq_n_q <= irq_n;
		if (irq_n_q === 1'b1 && irq_n === 1'b0)
			n_req <= n_req + 1;
	end
endmodule

// [dv/phy_irq_mask_and_mode_control_test.sv]
`timescale 1ns/10ps
module phy_irq_mask_and_mode_control_test;
	import pimc_pkg::*;
	logic aclk, aresetn, awv, awr, wv, wr_, bv, br, arv, arr, rv, rr, sd, be, we, rs;
	logic irq_n, t3a, pan, prom, lok, ld, ldq;
	logic [31:0] awa, wd, ara, rd;
	logic [3:0] ws, tm;
	logic [1:0] bresp, rresp, cca;
	logic [15:0] el, sc;
	logic [6:0] rl;
	int n_errors, compares, cyc, n_req;
	pimc_regs dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wr_), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
		.s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rr), .timer_match(tm),
		.event_timer_low(el), .secondary_compare_two(sc), .security_done(sd),
		.buffer_error(be), .wake_event(we), .rx_len_strobe(rs), .rx_len_in(rl), .irq_n(irq_n),
		.timer_three_abort_en(t3a), .pan_coordinator_first(pan), .channel_assess_type(cca),
		.promiscuous_en(prom), .frame_length_ok(lok), .event_timer_load(ld));
	pimc_host_model host (.aclk(aclk), .irq_n(irq_n), .n_req(n_req));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic ta, tw, got;
		@(posedge aclk);
		awa <= {24'h000000, a};
		wd <= {24'h000000, d};
		awv <= 1'b1;
		wv <= 1'b1;
		br <= 1'b1;
		got = 1'b0;
		// ready is registered, so its mid-cycle value is what the next edge samples
		while (awv || wv)
		begin
			@(negedge aclk);
			ta = awv && awr;
			tw = wv && wr_;
			@(posedge aclk);
			if (ta)
				awv <= 1'b0;
			if (tw)
				wv <= 1'b0;
		end
		while (!got)
		begin
			@(negedge aclk);
			got = bv;
			ldq = ld;
			@(posedge aclk);
		end
		br <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
		logic got, ta;
		@(posedge aclk);
		ara <= {24'h000000, a};
		arv <= 1'b1;
		rr <= 1'b1;
		got = 1'b0;
		while (!got)
		begin
			@(negedge aclk);
			ta = arv && arr;
			got = rv;
			if (got)
				chk(rd, {24'h000000, exp});
			@(posedge aclk);
			if (ta)
				arv <= 1'b0;
		end
		rr <= 1'b0;
	endtask
	task automatic ev(input logic [3:0] m, input logic s, input logic b, input logic w);
		tm <= m;
		sd <= s;
		be <= b;
		we <= w;
		@(posedge aclk);
		{tm, sd, be, we} <= 7'h00;
		@(posedge aclk);
		@(negedge aclk);
	endtask
	task automatic report_and_stop;
		if (n_errors == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic t_reset;
		rdc(8'h14, PIMC_CTRL3_RST);
		rdc(8'h1C, PIMC_CTRL4_RST);
		rdc(8'h18, 8'h00);
		rdc(8'h3C, 8'h00);
		rdc(8'h40, 8'h00);
		rdc(8'h44, PIMC_XMASK_RST);
		chk(irq_n, 1'b1);
		chk(cca, 2'h1);
	endtask
	task automatic t_modes;
		wr(8'h14, 8'hFF);
		rdc(8'h14, 8'hF7);
		for (int i = 0; i < 4; i++)
		begin
			wr(8'h1C, {3'h3, i[1:0], 3'h7});
			chk(ldq, 1'b1);
			rdc(8'h1C, {3'h3, i[1:0], 3'h3});
			chk(cca, i[1:0]);
			chk({t3a, pan, prom}, 3'h7);
		end
		wr(8'h1C, 8'h00);
		chk({ldq, t3a, pan, prom}, 4'h0);
	endtask
	task automatic t_irq;
		wr(8'h14, 8'h00);
		ev(4'hF, 1'b0, 1'b0, 1'b0);
		rdc(8'h40, 8'h00);
		wr(8'h14, 8'hF0);
		ev(4'hF, 1'b0, 1'b0, 1'b0);
		chk(irq_n, 1'b0);
		rdc(8'h40, 8'hF0);
		chk(irq_n, 1'b1);
		wr(8'h14, 8'h07);
		ev(4'h0, 1'b1, 1'b1, 1'b1);
		chk(irq_n, 1'b1);
		rdc(8'h40, 8'h07);
		wr(8'h14, 8'h00);
		wr(8'h1C, 8'h80);
		ev(4'h0, 1'b0, 1'b0, 1'b1);
		chk(irq_n, 1'b1);
		wr(8'h1C, 8'h00);
		@(negedge aclk);
		chk(irq_n, 1'b0);
		rdc(8'h40, 8'h01);
		chk(n_req > 0, 1'b1);
		wr(8'h44, 8'hF0);
		wr(8'h14, 8'hF0);
		ev(4'hF, 1'b0, 1'b0, 1'b0);
		chk(irq_n, 1'b1);
		rdc(8'h40, 8'hF0);
		rdc(8'h44, 8'hF0);
		wr(8'h44, 8'h00);
		wr(8'h14, 8'h00);
	endtask
	task automatic t_sec_len;
		wr(8'h1C, 8'h01);
		el <= 16'h1234;
		repeat (3) @(posedge aclk);
		rdc(8'h40, 8'h20);
		rl <= 7'h04;
		rs <= 1'b1;
		@(posedge aclk);
		rs <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(lok, 1'b0);
		rdc(8'h18, 8'h04);
		rl <= 7'h05;
		rs <= 1'b1;
		@(posedge aclk);
		rs <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(lok, 1'b1);
		rl <= 7'h7F;
		rs <= 1'b1;
		@(posedge aclk);
		rs <= 1'b0;
		repeat (2) @(posedge aclk);
		chk(lok, 1'b1);
		rdc(8'h18, 8'h7F);
	endtask
	initial
	begin
		aclk = 1'b0;
		forever #20 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			n_errors++;
			report_and_stop;
		end
	end
	initial
	begin
		{aresetn, awv, wv, br, arv, rr, sd, be, we, rs} = 10'h000;
		{awa, wd, ara} = 96'h0;
		ws = 4'hF;
		tm = 4'h0;
		el = 16'h0000;
		sc = 16'h1234;
		rl = 7'h00;
		repeat (16) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		t_reset;
		t_modes;
		t_irq;
		t_sec_len;
		report_and_stop;
	end
endmodule
